// >>> design/mpio_pin_ctrl.sv
`include "mpio_defines.svh"

module mpio_pin_ctrl
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [7:0] reg_page,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic bidir_gpo_mode,
   input wire logic bidir_gpi_mode,
   input wire mpio_pkg::mpio_out_func_t out_pin1_function,
   input wire mpio_pkg::mpio_out_func_t out_pin2_function,
   input wire mpio_pkg::mpio_out_func_t out_pin3_function,
   input wire mpio_pkg::mpio_out_func_t out_pin4_function,
   input wire logic bidir_pin_i,
   output logic bidir_pin_o,
   output logic bidir_pin_oe,
   output logic out_pin1_o,
   output logic out_pin1_oe,
   output logic out_pin2_o,
   output logic out_pin2_oe,
   output logic out_pin3_o,
   output logic out_pin3_oe,
   output logic out_pin4_o,
   output logic out_pin4_oe,
   input wire logic in_pin1,
   input wire logic in_pin2,
   input wire logic in_pin3,
   input wire logic in_pin4,
   output logic in_pin1_gpi,
   output logic in_pin2_gpi,
   output logic in_pin3_gpi,
   output logic in_pin4_gpi,
   output logic master_clk_in,
   output logic daisy_chain_serial_in,
   output logic pdm_data_in_pair1,
   output logic pdm_data_in_pair2,
   output logic pdm_data_in_pair3,
   output logic pdm_data_in_pair4
);
   import mpio_pkg::*;

   mpio_state_t s;
   mpio_state_t next_s;
   logic [`MPIO_SYNC_WIDTH-1:0] sync_lv;
   logic page_ok;
   logic wr_hit;

   mpio_sync u_sync
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .async_in({bidir_pin_i, in_pin4, in_pin3, in_pin2, in_pin1}),
      .sync_out(sync_lv)
   );

   // Lowest-numbered pin wins when several pick the same route
   function automatic logic route_pick(input mpio_in_func_t f1, input mpio_in_func_t f2,
                                       input mpio_in_func_t f3, input mpio_in_func_t f4,
                                       input logic [3:0] lv, input mpio_in_func_t code);
      logic r;
      r = 1'b0;
      if (f4 == code)
         r = lv[3];
      if (f3 == code)
         r = lv[2];
      if (f2 == code)
         r = lv[1];
      if (f1 == code)
         r = lv[0];
      return r;
   endfunction

   function automatic logic [7:0] read_mux(input mpio_state_t st, input logic [7:0] addr);
      logic [7:0] d;
      d = 8'h00;
      case (addr)
         `MPIO_ADDR_OUT_LEVELS:
            d = st.output_pin_levels & `MPIO_MASK_OUT_LEVELS;
         `MPIO_ADDR_BIDIR_MON:
            d = {st.bidir_pin_in_level, 7'h00};
         `MPIO_ADDR_IN_SEL_A:
            d = {1'b0, st.in_pin1_function, 1'b0, st.in_pin2_function};
         `MPIO_ADDR_IN_SEL_B:
            d = {1'b0, st.in_pin3_function, 1'b0, st.in_pin4_function};
         default:
            d = 8'h00;
      endcase
      return d;
   endfunction

   function automatic logic is_gpo(input mpio_out_func_t f);
      return f == `MPIO_OUT_FUNC_GPO;
   endfunction

   assign page_ok = reg_page == `MPIO_PAGE;
   assign wr_hit = reg_wr && page_ok;

   always_comb
   begin
      next_s = s;
      if (s.warm != `MPIO_WARM_DONE)
         next_s.warm = s.warm + 2'h1;
      // Reserved bits are dropped on write so they always read zero
      if (wr_hit)
      begin
         case (reg_addr)
            `MPIO_ADDR_OUT_LEVELS:
               next_s.output_pin_levels = reg_wdata & `MPIO_MASK_OUT_LEVELS;
            `MPIO_ADDR_IN_SEL_A:
            begin
               next_s.in_pin1_function =
                  mpio_in_func_t'(reg_wdata[`MPIO_SEL_HI_MSB:`MPIO_SEL_HI_LSB]);
               next_s.in_pin2_function =
                  mpio_in_func_t'(reg_wdata[`MPIO_SEL_LO_MSB:`MPIO_SEL_LO_LSB]);
            end
            `MPIO_ADDR_IN_SEL_B:
            begin
               next_s.in_pin3_function =
                  mpio_in_func_t'(reg_wdata[`MPIO_SEL_HI_MSB:`MPIO_SEL_HI_LSB]);
               next_s.in_pin4_function =
                  mpio_in_func_t'(reg_wdata[`MPIO_SEL_LO_MSB:`MPIO_SEL_LO_LSB]);
            end
            default:
               next_s.warm = next_s.warm;
         endcase
      end
      // Monitor holds its last sample while the pin is not an input
      if (bidir_gpi_mode)
         next_s.bidir_pin_in_level = sync_lv[4];
      // Other pages and unmapped addresses answer zero
      next_s.reg_rvalid = reg_rd;
      if (reg_rd)
         next_s.reg_rdata = page_ok ? read_mux(s, reg_addr) : 8'h00;
      next_s.bidir_oe = bidir_gpo_mode;
      next_s.bidir_o = bidir_gpo_mode & s.output_pin_levels[`MPIO_BIT_BIDIR];
      // Pin released outside general output; stored level untouched
      next_s.out_oe[0] = is_gpo(out_pin1_function);
      next_s.out_oe[1] = is_gpo(out_pin2_function);
      next_s.out_oe[2] = is_gpo(out_pin3_function);
      next_s.out_oe[3] = is_gpo(out_pin4_function);
      next_s.out_o[0] = next_s.out_oe[0] & s.output_pin_levels[`MPIO_BIT_OUT1];
      next_s.out_o[1] = next_s.out_oe[1] & s.output_pin_levels[`MPIO_BIT_OUT2];
      next_s.out_o[2] = next_s.out_oe[2] & s.output_pin_levels[`MPIO_BIT_OUT3];
      next_s.out_o[3] = next_s.out_oe[3] & s.output_pin_levels[`MPIO_BIT_OUT4];
      next_s.gpi_level[0] = (s.in_pin1_function == MPIO_IN_GENERAL) & sync_lv[0];
      next_s.gpi_level[1] = (s.in_pin2_function == MPIO_IN_GENERAL) & sync_lv[1];
      next_s.gpi_level[2] = (s.in_pin3_function == MPIO_IN_GENERAL) & sync_lv[2];
      next_s.gpi_level[3] = (s.in_pin4_function == MPIO_IN_GENERAL) & sync_lv[3];
      // Clock route passes through two sync stages, so only slow clocks survive
      next_s.master_clk_in = route_pick(s.in_pin1_function, s.in_pin2_function,
         s.in_pin3_function, s.in_pin4_function, sync_lv[3:0], MPIO_IN_MCLK);
      next_s.daisy_chain_serial_in = route_pick(s.in_pin1_function, s.in_pin2_function,
         s.in_pin3_function, s.in_pin4_function, sync_lv[3:0], MPIO_IN_DAISY);
      next_s.pdm_data_in[0] = route_pick(s.in_pin1_function, s.in_pin2_function,
         s.in_pin3_function, s.in_pin4_function, sync_lv[3:0], MPIO_IN_PDM12);
      next_s.pdm_data_in[1] = route_pick(s.in_pin1_function, s.in_pin2_function,
         s.in_pin3_function, s.in_pin4_function, sync_lv[3:0], MPIO_IN_PDM34);
      next_s.pdm_data_in[2] = route_pick(s.in_pin1_function, s.in_pin2_function,
         s.in_pin3_function, s.in_pin4_function, sync_lv[3:0], MPIO_IN_PDM56);
      next_s.pdm_data_in[3] = route_pick(s.in_pin1_function, s.in_pin2_function,
         s.in_pin3_function, s.in_pin4_function, sync_lv[3:0], MPIO_IN_PDM78);
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.reg_rdata;
   assign reg_rvalid = s.reg_rvalid;
   assign bidir_pin_o = s.bidir_o;
   assign bidir_pin_oe = s.bidir_oe;
   assign out_pin1_o = s.out_o[0];
   assign out_pin1_oe = s.out_oe[0];
   assign out_pin2_o = s.out_o[1];
   assign out_pin2_oe = s.out_oe[1];
   assign out_pin3_o = s.out_o[2];
   assign out_pin3_oe = s.out_oe[2];
   assign out_pin4_o = s.out_o[3];
   assign out_pin4_oe = s.out_oe[3];
   assign in_pin1_gpi = s.gpi_level[0];
   assign in_pin2_gpi = s.gpi_level[1];
   assign in_pin3_gpi = s.gpi_level[2];
   assign in_pin4_gpi = s.gpi_level[3];
   assign master_clk_in = s.master_clk_in;
   assign daisy_chain_serial_in = s.daisy_chain_serial_in;
   assign pdm_data_in_pair1 = s.pdm_data_in[0];
   assign pdm_data_in_pair2 = s.pdm_data_in[1];
   assign pdm_data_in_pair3 = s.pdm_data_in[2];
   assign pdm_data_in_pair4 = s.pdm_data_in[3];

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   sequence seq_wr_levels;
      reg_wr && page_ok && reg_addr == `MPIO_ADDR_OUT_LEVELS;
   endsequence

   sequence seq_rd_levels_only;
      !reg_wr && reg_rd && page_ok && reg_addr == `MPIO_ADDR_OUT_LEVELS;
   endsequence

   sequence seq_wr_sel_a;
      reg_wr && page_ok && reg_addr == `MPIO_ADDR_IN_SEL_A;
   endsequence

   AST_BIDIR_DRIVE: assert property (bidir_gpo_mode |=>
      bidir_pin_oe && bidir_pin_o == $past(s.output_pin_levels[7]))
      else $error("bidir pin not driven from level bit 7");

   AST_OUT1_DRIVE: assert property (is_gpo(out_pin1_function) |=>
      out_pin1_oe && out_pin1_o == $past(s.output_pin_levels[6]))
      else $error("output pin 1 not following bit 6");

   AST_OUT234_DRIVE: assert property ((is_gpo(out_pin2_function) &&
      is_gpo(out_pin3_function) && is_gpo(out_pin4_function)) |=>
      out_pin2_o == $past(s.output_pin_levels[5]) &&
      out_pin3_o == $past(s.output_pin_levels[4]) &&
      out_pin4_o == $past(s.output_pin_levels[3]))
      else $error("output pins 2-4 not following bits 5-3");

   AST_LEVELS_READBACK: assert property (seq_wr_levels ##1 seq_rd_levels_only |=>
      reg_rvalid && reg_rdata == ($past(reg_wdata, 2) & 8'hf8))
      else $error("output level readback wrong or reserved bits set");

   AST_MON_FOLLOWS: assert property ((s.warm == 2'h3 && bidir_gpi_mode) |=>
      s.bidir_pin_in_level == $past(bidir_pin_i, 3))
      else $error("monitor bit does not track bidir pin");

   AST_MON_RSV: assert property ((reg_rd && page_ok && reg_addr == 8'h2a) |=>
      reg_rvalid && reg_rdata[6:0] == 7'h00 && reg_rdata[7] == $past(s.bidir_pin_in_level))
      else $error("monitor register read wrong");

   AST_ROUTE_MCLK: assert property ((s.in_pin1_function == MPIO_IN_MCLK) |=>
      master_clk_in == $past(sync_lv[0]))
      else $error("input pin 1 not routed to master clock");

   // Pair 1 may legally come from another pin, so it is only checked when none claims it
   AST_ROUTE_PDM4: assert property ((s.in_pin1_function == MPIO_IN_PDM78) |=>
      pdm_data_in_pair4 == $past(sync_lv[0]) &&
      ($past(s.in_pin2_function == MPIO_IN_PDM12 || s.in_pin3_function == MPIO_IN_PDM12 ||
      s.in_pin4_function == MPIO_IN_PDM12) || pdm_data_in_pair1 == 1'b0))
      else $error("input pin 1 not routed to pdm pair 4");

   AST_SEL_A_FIELDS: assert property (seq_wr_sel_a |=>
      s.in_pin1_function == $past(reg_wdata[6:4]) &&
      s.in_pin2_function == $past(reg_wdata[2:0]))
      else $error("select A fields not captured");

   AST_RESET_VALUES: assert property ((s.warm == 2'h0) |->
      s.output_pin_levels == 8'h00 && s.in_pin1_function == MPIO_IN_OFF &&
      s.in_pin2_function == MPIO_IN_OFF && s.in_pin3_function == MPIO_IN_OFF &&
      s.in_pin4_function == MPIO_IN_OFF)
      else $error("register not zero after reset");

   AST_NOT_GPO_RELEASE: assert property ((!is_gpo(out_pin1_function) && !wr_hit) |=>
      !out_pin1_oe && !out_pin1_o && $stable(s.output_pin_levels))
      else $error("output pin 1 driven outside general output");

endmodule

// >>> shared/mpio_defines.svh
// Summary of operation
// - Bidirectional pin in output mode drives the level of output-level bit 7.
// - Output pin 1 in general output function drives output-level bit 6.
// - Output pins 2, 3, 4 in general output follow bits 5, 4, 3.
// - Output-level bits reset to zero, read back; bits 2-0 read zero.
// - Monitor bit 7 reports bidirectional pin level in input mode; rest zero.
// - Input pin 1 function in select A bits 6-4: off, general, clock, daisy.
// - Function codes 4-7 route the pin as PDM data for pairs 1-4.
// - Input pin 2 function in select A bits 2-0; bits 7, 3 zero.
// - Select A at page 0 address 0x2b resets to zero, pins disabled.
// - Select B at 0x2c resets zero; pins 3 and 4 in bits 6-4, 2-0.
// - Output pin is general output only when its function code is 1.
// - Output-level register sits at page 0 address 0x29, resets to zero.
`ifndef MPIO_DEFINES_SVH
`define MPIO_DEFINES_SVH

`define MPIO_PAGE 8'h00
`define MPIO_ADDR_OUT_LEVELS 8'h29
`define MPIO_ADDR_BIDIR_MON 8'h2a
`define MPIO_ADDR_IN_SEL_A 8'h2b
`define MPIO_ADDR_IN_SEL_B 8'h2c

`define MPIO_RST_OUT_LEVELS 8'h00
`define MPIO_RST_BIDIR_MON 8'h00
`define MPIO_RST_IN_SEL 8'h00

`define MPIO_MASK_OUT_LEVELS 8'hf8
`define MPIO_MASK_BIDIR_MON 8'h80
`define MPIO_MASK_IN_SEL 8'h77

`define MPIO_BIT_BIDIR 7
`define MPIO_BIT_OUT1 6
`define MPIO_BIT_OUT2 5
`define MPIO_BIT_OUT3 4
`define MPIO_BIT_OUT4 3
`define MPIO_BIT_MON 7
`define MPIO_SEL_HI_MSB 6
`define MPIO_SEL_HI_LSB 4
`define MPIO_SEL_LO_MSB 2
`define MPIO_SEL_LO_LSB 0

`define MPIO_OUT_FUNC_GPO 4'h1
`define MPIO_SYNC_WIDTH 5
`define MPIO_WARM_DONE 2'h3

`endif

// >>> shared/mpio_pkg.sv
package mpio_pkg;

   typedef enum logic [2:0]
   {
      MPIO_IN_OFF = 3'h0,
      MPIO_IN_GENERAL = 3'h1,
      MPIO_IN_MCLK = 3'h2,
      MPIO_IN_DAISY = 3'h3,
      MPIO_IN_PDM12 = 3'h4,
      MPIO_IN_PDM34 = 3'h5,
      MPIO_IN_PDM56 = 3'h6,
      MPIO_IN_PDM78 = 3'h7
   } mpio_in_func_t;

   typedef logic [3:0] mpio_out_func_t;

   typedef struct packed
   {
      logic [4:0] stage1;
      logic [4:0] stage2;
   } mpio_sync_state_t;

   typedef struct packed
   {
      logic [7:0] output_pin_levels;
      mpio_in_func_t in_pin1_function;
      mpio_in_func_t in_pin2_function;
      mpio_in_func_t in_pin3_function;
      mpio_in_func_t in_pin4_function;
      logic bidir_pin_in_level;
      logic [7:0] reg_rdata;
      logic reg_rvalid;
      logic bidir_o;
      logic bidir_oe;
      logic [3:0] out_o;
      logic [3:0] out_oe;
      logic [3:0] gpi_level;
      logic master_clk_in;
      logic daisy_chain_serial_in;
      logic [3:0] pdm_data_in;
      logic [1:0] warm;
   } mpio_state_t;

endpackage

// >>> design/mpio_sync.sv
`include "mpio_defines.svh"

module mpio_sync
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [`MPIO_SYNC_WIDTH-1:0] async_in,
   output logic [`MPIO_SYNC_WIDTH-1:0] sync_out
);
   import mpio_pkg::*;

   mpio_sync_state_t s;
   mpio_sync_state_t next_s;

   // First stage feeds only the second; nothing else may look at it
   always_comb
   begin
      next_s = s;
      next_s.stage1 = async_in;
      next_s.stage2 = s.stage1;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign sync_out = s.stage2;

endmodule

// >>> verif/mpio_pin_partner.sv
module mpio_pin_partner
(
   input wire logic mclk,
   input wire logic [4:0] want,
   input wire logic bidir_pin_o,
   input wire logic bidir_pin_oe,
   output logic [3:0] in_pins,
   output logic bidir_pin_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] pins = 5'h00;
   // Far side moves its levels on the clock edge, never mid-cycle
   always @(posedge mclk)
      pins <= want;
   assign in_pins = pins[3:0];
   // Shared wire: device drive wins, otherwise the far side's level
   assign bidir_pin_i = bidir_pin_oe ? bidir_pin_o : pins[4];
endmodule

// >>> verif/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import mpio_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] reg_page = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00;
   logic reg_wr = 1'b0, reg_rd = 1'b0, gpo_m = 1'b0, gpi_m = 1'b0;
   logic [7:0] reg_rdata;
   logic reg_rvalid, bo, boe, bi, mck, dsy;
   logic [3:0] po, poe, pin, gpi, pdm;
   logic [4:0] want = 5'h00;
   mpio_out_func_t ofn [4] = '{default: 4'h0};
   logic [9:0] expq [$];
   int fails = 0, checks_done = 0;
   logic [31:0] rs = 32'hdecee331;

   always #12.5 mclk = ~mclk;

   mpio_pin_ctrl dut_u (.mclk(mclk), .reset_n(reset_n), .reg_page(reg_page),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .bidir_gpo_mode(gpo_m),
      .bidir_gpi_mode(gpi_m), .out_pin1_function(ofn[0]), .out_pin2_function(ofn[1]),
      .out_pin3_function(ofn[2]), .out_pin4_function(ofn[3]), .bidir_pin_i(bi),
      .bidir_pin_o(bo), .bidir_pin_oe(boe), .out_pin1_o(po[0]), .out_pin1_oe(poe[0]),
      .out_pin2_o(po[1]), .out_pin2_oe(poe[1]), .out_pin3_o(po[2]), .out_pin3_oe(poe[2]),
      .out_pin4_o(po[3]), .out_pin4_oe(poe[3]), .in_pin1(pin[0]), .in_pin2(pin[1]),
      .in_pin3(pin[2]), .in_pin4(pin[3]), .in_pin1_gpi(gpi[3]), .in_pin2_gpi(gpi[2]),
      .in_pin3_gpi(gpi[1]), .in_pin4_gpi(gpi[0]), .master_clk_in(mck),
      .daisy_chain_serial_in(dsy), .pdm_data_in_pair1(pdm[3]), .pdm_data_in_pair2(pdm[2]),
      .pdm_data_in_pair3(pdm[1]), .pdm_data_in_pair4(pdm[0]));

   mpio_pin_partner far_u (.mclk(mclk), .want(want), .bidir_pin_o(bo),
      .bidir_pin_oe(boe), .in_pins(pin), .bidir_pin_i(bi));

   function logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   // Strobe is lowered and a further edge passes, so calls may follow directly
   task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
      reg_page = pg;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask

   task automatic rd(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] e);
      expq.push_back({2'b00, e});
      reg_page = pg;
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      tick(1);
   endtask

   // Read in the cycle right behind the write must already see the new value
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      expq.push_back({2'b00, e});
      reg_page = 8'h00;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      tick(1);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Read answers are sampled mid-cycle, well clear of the launching edge
   always @(negedge mclk)
      if (reg_rvalid === 1'b1)
      begin
         check("reg read", {2'b00, reg_rdata}, expq.pop_front());
      end

   initial
   begin
      #(25 * 20000);
      fails++;
      report_and_stop();
   end

   initial
   begin
      logic [31:0] r;
      logic [2:0] c3;
      logic [9:0] e;
      logic mon;
      mon = 1'b0;
      tick(10);
      reset_n = 1'b1;
      rd(8'h00, 8'h29, 8'h00);
      rd(8'h00, 8'h2a, 8'h00);
      rd(8'h00, 8'h2b, 8'h00);
      rd(8'h00, 8'h2c, 8'h00);
      rd(8'h00, 8'h30, 8'h00);
      wr(8'h00, 8'h29, 8'hff);
      rd(8'h00, 8'h29, 8'hf8);
      rd(8'h01, 8'h29, 8'h00);
      wr(8'h01, 8'h29, 8'h00);
      rd(8'h00, 8'h29, 8'hf8);
      wr_rd(8'h29, 8'h5a, 8'h58);
      wr(8'h00, 8'h2b, 8'hff);
      rd(8'h00, 8'h2b, 8'h77);
      wr(8'h00, 8'h2c, 8'hff);
      rd(8'h00, 8'h2c, 8'h77);
      wr(8'h00, 8'h2a, 8'hff);
      rd(8'h00, 8'h2a, 8'h00);
      for (int i = 0; i < 10; i++)
      begin
         r = rnd();
         for (int n = 0; n < 4; n++)
            ofn[n] = (r[n + 8] | (i == 0)) ? 4'h1 : r[4 * n + 12 +: 4];
         gpo_m = r[28];
         wr(8'h00, 8'h29, r[7:0]);
         tick(2);
         check("bidir drive", {8'h00, boe, bo}, {8'h00, r[28], r[28] & r[7]});
         for (int n = 0; n < 4; n++)
            check("out drive", {8'h00, poe[n], po[n]},
               {8'h00, ofn[n] == 4'h1, (ofn[n] == 4'h1) & r[6 - n]});
         rd(8'h00, 8'h29, r[7:0] & 8'hf8);
      end
      gpo_m = 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         r = rnd();
         want[4] = (i < 2) ? i[0] : r[0];
         gpi_m = r[1] | (i < 2);
         tick(6);
         if (gpi_m)
            mon = want[4];
         rd(8'h00, 8'h2a, {mon, 7'h00});
      end
      gpi_m = 1'b0;
      for (int p = 0; p < 4; p++)
         for (int c = 0; c < 8; c++)
         begin
            c3 = c[2:0];
            wr(8'h00, 8'h2b, {1'b0, p == 0 ? c3 : 3'h0, 1'b0, p == 1 ? c3 : 3'h0});
            wr(8'h00, 8'h2c, {1'b0, p == 2 ? c3 : 3'h0, 1'b0, p == 3 ? c3 : 3'h0});
            rd(8'h00, 8'h2b, {1'b0, p == 0 ? c3 : 3'h0, 1'b0, p == 1 ? c3 : 3'h0});
            rd(8'h00, 8'h2c, {1'b0, p == 2 ? c3 : 3'h0, 1'b0, p == 3 ? c3 : 3'h0});
            for (int k = 0; k < 2; k++)
            begin
               r = rnd();
               want[3:0] = k ? ~want[3:0] : r[3:0];
               tick(6);
               e = 10'h000;
               if (c == 1)
                  e[9 - p] = want[p];
               if (c >= 2)
                  e[7 - c] = want[p];
               check("input route", {gpi, mck, dsy, pdm}, e);
            end
         end
      check("reads left", 10'(expq.size()), 10'h000);
      report_and_stop();
   end
endmodule
